// *** rtl/uhiasr_top.sv ***
// Host controller event status, enables, interrupt gating and software reset.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "uhiasr_map.svh"
// What this block does
// (RULE1) Soft reset command forces suspend, clears registers, keeps interrupt routing.
// (RULE2) Soft reset finishes within 10 us, then command bit clears itself.
// (RULE3) Soft reset never resets root hub nor signals reset downstream.
// (RULE4) No host bus accesses while soft reset is in progress.
// (RULE5) Each tracked event sets its matching status bit.
// (RULE6) Writing one clears a status bit; zero leaves it; writes never set.
// (RULE7) Hardware never clears a status bit; it stays until software clears.
// (RULE8) Interrupt when a status bit, its enable and master enable are set.
// (RULE9) Enable register writes set ones, ignore zeros; reads return its value.
// (RULE10) Disable register writes of one clear the matching enable bit.
// (RULE11) Disable register reads return the enable register contents.
// (RULE12) Bit 31 is master enable, set by one through enable register.
// (RULE13) Event bits: 30, 6, 5, 4, 3, 2, 1, 0; bits 29 to 7 reserved.
// (RULE14) All enable bits including master enable reset to zero.
// (RULE15) Enable and disable bits map one to one onto status bits.
// (RULE16) Functional state codes reset, resume, operational, suspend; soft reset gives suspend.
// (RULE17) Routing bit clear sends interrupt to host bus, set to management.
// (RULE18) Interrupt is a level, dropping the cycle after its condition ends.
module uhiasr_top #(
   parameter int SRST_CYCLES = `UHIASR_SRST_CYC
) (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [31:0] evt_in,
   output logic irq_out,
   output logic smi_out,
   output logic bus_access_en_out,
   output logic port_reset_out,
   output logic soft_reset_busy_out
);
   typedef struct packed {
      logic [31:0] status;
      logic [31:0] enable;
      uhiasr_pkg::uhiasr_fs_e fs;
      logic route;
      logic irq;
      logic smi;
   } uhiasr_regs_s;

   localparam int SRST_LIM = 1000;

   if (SRST_CYCLES < 1 || SRST_CYCLES > SRST_LIM) begin : g_bad_srst
      $error("Software reset length out of range.");
   end

   logic [1:0] rst_sync;
   logic rst_n;
   uhiasr_regs_s q;
   uhiasr_regs_s next_q;
   logic srst_start;
   logic srst_busy;
   logic srst_done;
   logic [31:0] evt;
   logic [31:0] pend;
   logic gate;
   logic st_wr;
   logic en_wr;
   logic dis_wr;
   logic ctrl_wr;
   logic dis_rd;
   logic [31:0] rdata;

   uhiasr_reg_if rif ();

   // =====================================================
   // Reset synchroniser
   // =====================================================
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // =====================================================
   // Bus slave and soft reset sequencer
   // =====================================================
   uhiasr_apb_slave u_apb (
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .rif(rif.bus)
   );

   uhiasr_srst_seq #(.SRST_CYCLES(SRST_CYCLES)) u_seq (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .start_in(srst_start),
      .busy_out(srst_busy),
      .done_out(srst_done)
   );

   // =====================================================
   // Access decode
   // =====================================================
   assign st_wr = rif.wr && (rif.addr == `UHIASR_OFS_STATUS);
   assign en_wr = rif.wr && (rif.addr == `UHIASR_OFS_EN_SET);
   assign dis_wr = rif.wr && (rif.addr == `UHIASR_OFS_EN_CLR);
   assign ctrl_wr = rif.wr && (rif.addr == `UHIASR_OFS_CTRL);
   assign dis_rd = rif.rd && (rif.addr == `UHIASR_OFS_EN_CLR);
   assign srst_start = rif.wr && (rif.addr == `UHIASR_OFS_CMD) &&
                       rif.wdata[`UHIASR_SRST_BIT] && !srst_busy; // [RULE1]

   // Only documented event positions can ever be set.
   assign evt = evt_in & `UHIASR_STATUS_MASK; // [RULE13]
   assign pend = q.status & q.enable & `UHIASR_STATUS_MASK; // [RULE15]
   assign gate = (|pend) && q.enable[`UHIASR_MIE_BIT]; // [RULE8]

   // =====================================================
   // Register update
   // =====================================================
   always_comb begin
      next_q = q;
      if (srst_start) begin
         next_q.status = `UHIASR_STATUS_RESET; // [RULE1]
         next_q.enable = `UHIASR_ENABLE_RESET; // [RULE1]
         next_q.fs = uhiasr_pkg::FS_SUSPEND; // [RULE16]
      end else begin
         if (st_wr) begin
            next_q.status = q.status & ~rif.wdata; // [RULE6]
         end
         if (en_wr) begin
            next_q.enable = q.enable | (rif.wdata & `UHIASR_ENABLE_MASK); // [RULE9] [RULE12]
         end
         if (dis_wr) begin
            next_q.enable = q.enable & ~rif.wdata; // [RULE10]
         end
         if (ctrl_wr && !srst_busy) begin
            next_q.fs = uhiasr_pkg::uhiasr_fs_e'(rif.wdata[`UHIASR_FS_LSB +: 2]);
         end
      end
      if (ctrl_wr) begin
         next_q.route = rif.wdata[`UHIASR_ROUTE_BIT];
      end
      // An event in the cycle of a clear still lands.
      next_q.status = next_q.status | evt; // [RULE5] [RULE7]
      next_q.irq = gate && !q.route; // [RULE17] [RULE18]
      next_q.smi = gate && q.route; // [RULE17]
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         q.status <= `UHIASR_STATUS_RESET;
         q.enable <= `UHIASR_ENABLE_RESET; // [RULE14]
         q.fs <= uhiasr_pkg::FS_RESET;
         q.route <= 1'b0;
         q.irq <= 1'b0;
         q.smi <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   // =====================================================
   // Read data
   // =====================================================
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (rif.addr)
         `UHIASR_OFS_CTRL: begin
            rdata[`UHIASR_FS_LSB +: 2] = q.fs;
            rdata[`UHIASR_ROUTE_BIT] = q.route;
         end
         `UHIASR_OFS_CMD: rdata[`UHIASR_SRST_BIT] = srst_busy; // [RULE2]
         `UHIASR_OFS_STATUS: rdata = q.status;
         `UHIASR_OFS_EN_SET: rdata = q.enable; // [RULE9]
         `UHIASR_OFS_EN_CLR: rdata = q.enable; // [RULE11]
         default: rdata = 32'h0000_0000;
      endcase
   end
   assign rif.rdata = rdata;

   // =====================================================
   // Outputs
   // =====================================================
   assign irq_out = q.irq;
   assign smi_out = q.smi;
   assign soft_reset_busy_out = srst_busy;
   assign bus_access_en_out = !srst_busy && (q.fs == uhiasr_pkg::FS_OPER); // [RULE4]
   // Only the FS_RESET functional state, outside soft reset, drives downstream reset.
   assign port_reset_out = (q.fs == uhiasr_pkg::FS_RESET) && !srst_busy; // [RULE3]

   // =====================================================
   // Checks
   // =====================================================
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n);

   sequence srst_req_s;
      srst_start;
   endsequence

   sequence srst_run_s;
      srst_busy ##[0:SRST_LIM] !srst_busy;
   endsequence

   srst_suspend_a: assert property (srst_req_s |=> q.fs == uhiasr_pkg::FS_SUSPEND) // [RULE1]
      else $error("Soft reset did not enter suspend.");

   srst_route_keep_a: assert property ((srst_req_s and !ctrl_wr) |=> $stable(q.route)) // [RULE1]
      else $error("Soft reset changed interrupt routing.");

   srst_bound_a: assert property (srst_req_s |=> srst_run_s) // [RULE2]
      else $error("Soft reset exceeded its time limit.");

   srst_no_port_a: assert property (srst_busy |-> !port_reset_out) // [RULE3]
      else $error("Port reset driven during soft reset.");

   srst_no_bus_a: assert property (srst_busy |-> !bus_access_en_out) // [RULE4]
      else $error("Bus access allowed during soft reset.");

   evt_set_a: assert property (|evt |=> (q.status & $past(evt)) == $past(evt)) // [RULE5]
      else $error("Event did not set its status bit.");

   status_w1c_a: assert property (st_wr && evt == 32'h0 && !srst_start
         |=> q.status == ($past(q.status) & ~$past(rif.wdata))) // [RULE6]
      else $error("Status write did not clear exactly the written ones.");

   status_hold_a: assert property (!st_wr && !srst_start
         |=> (q.status & $past(q.status)) == $past(q.status)) // [RULE7]
      else $error("Status bit cleared by hardware.");

   enable_set_a: assert property (en_wr && !srst_start
         |=> q.enable == ($past(q.enable) | ($past(rif.wdata) & `UHIASR_ENABLE_MASK))) // [RULE9]
      else $error("Enable set write misbehaved.");

   enable_clr_a: assert property (dis_wr && !srst_start
         |=> q.enable == ($past(q.enable) & ~$past(rif.wdata))) // [RULE10]
      else $error("Enable clear write misbehaved.");

   dis_read_a: assert property (dis_rd |-> prdata_out == q.enable) // [RULE11]
      else $error("Disable register read differs from enable register.");

   irq_level_a: assert property (gate && !q.route |=> irq_out) // [RULE8]
      else $error("Interrupt not raised for enabled pending event.");

   irq_drop_a: assert property (!gate |=> !irq_out && !smi_out) // [RULE18]
      else $error("Interrupt stayed high after its condition ended.");

   smi_route_a: assert property (gate && q.route |=> smi_out && !irq_out) // [RULE17]
      else $error("Routed interrupt went to the wrong output.");

   // =====================================================
   // Soft reset, register and interrupt checks
   // =====================================================
   sequence srst_clean_s;
      q.enable == `UHIASR_ENABLE_RESET && q.fs == uhiasr_pkg::FS_SUSPEND;
   endsequence

   sequence irq_quiet_s;
      !irq_out && !smi_out;
   endsequence

   srst_clear_a: assert property ( // [RULE1]
         srst_req_s |=> srst_clean_s ##0 q.status == $past(evt))
      else $error("Soft reset did not clear the registers.");

   srst_quiet_a: assert property ( // [RULE1]
         srst_req_s |=> ##1 irq_quiet_s)
      else $error("Interrupt still raised after soft reset.");

   srst_busy_a: assert property ( // [RULE2]
         srst_req_s |=> srst_busy)
      else $error("Soft reset did not start.");

   srst_done_a: assert property ( // [RULE2]
         srst_done |=> !srst_busy)
      else $error("Soft reset busy after its end.");

   cmd_read_a: assert property ( // [RULE2]
         rif.rd && rif.addr == `UHIASR_OFS_CMD |-> prdata_out[`UHIASR_SRST_BIT] == srst_busy)
      else $error("Command bit read differs from soft reset state.");

   port_reset_a: assert property ( // [RULE3]
         port_reset_out |-> q.fs == uhiasr_pkg::FS_RESET)
      else $error("Port reset driven outside the reset state.");

   status_read_a: assert property ( // [RULE5]
         rif.rd && rif.addr == `UHIASR_OFS_STATUS |-> prdata_out == q.status)
      else $error("Status read differs from status register.");

   status_no_set_a: assert property ( // [RULE6]
         st_wr && evt == 32'h0 && !srst_start |=> (q.status & ~$past(q.status)) == 32'h0)
      else $error("Status write set a status bit.");

   irq_cause_a: assert property ( // [RULE8]
         irq_out |-> $past(gate) && !$past(q.route))
      else $error("Interrupt raised without an enabled pending event.");

   enable_read_a: assert property ( // [RULE9]
         rif.rd && rif.addr == `UHIASR_OFS_EN_SET |-> prdata_out == q.enable)
      else $error("Enable read differs from enable register.");

   mie_set_a: assert property ( // [RULE12]
         en_wr && !srst_start && rif.wdata[`UHIASR_MIE_BIT] |=> q.enable[`UHIASR_MIE_BIT])
      else $error("Master enable not set by a one write.");

   mie_keep_a: assert property ( // [RULE12]
         en_wr && !srst_start && !rif.wdata[`UHIASR_MIE_BIT]
         |=> q.enable[`UHIASR_MIE_BIT] == $past(q.enable[`UHIASR_MIE_BIT]))
      else $error("Master enable changed by a zero write.");

   status_rsvd_a: assert property ( // [RULE13]
         (q.status & ~`UHIASR_STATUS_MASK) == 32'h0)
      else $error("Reserved status bit set.");

   enable_rsvd_a: assert property ( // [RULE13]
         (q.enable & ~`UHIASR_ENABLE_MASK) == 32'h0)
      else $error("Reserved enable bit set.");

   fs_busy_hold_a: assert property ( // [RULE16]
         srst_busy && !srst_start |=> q.fs == uhiasr_pkg::FS_SUSPEND)
      else $error("Functional state left suspend during soft reset.");

   smi_cause_a: assert property ( // [RULE17]
         smi_out |-> $past(gate) && $past(q.route))
      else $error("Management interrupt raised without routed event.");

   route_write_a: assert property ( // [RULE17]
         ctrl_wr |=> q.route == $past(rif.wdata[`UHIASR_ROUTE_BIT]))
      else $error("Routing bit not taken from control write.");
endmodule // uhiasr_top

// *** rtl/uhiasr_map.svh ***
// Register offsets, field positions, reset values and timing counts of the block.
`ifndef UHIASR_MAP_SVH
`define UHIASR_MAP_SVH
`define UHIASR_ADDR_W 16
`define UHIASR_OFS_CTRL 16'hd004
`define UHIASR_OFS_CMD 16'hd008
`define UHIASR_OFS_STATUS 16'hd00c
`define UHIASR_OFS_EN_SET 16'hd010
`define UHIASR_OFS_EN_CLR 16'hd014
`define UHIASR_STATUS_MASK 32'h4000_007f
`define UHIASR_ENABLE_MASK 32'hc000_007f
`define UHIASR_MIE_BIT 31
`define UHIASR_OC_BIT 30
`define UHIASR_ROOT_HUB_CHANGE_EVT_BIT 6
`define UHIASR_FNO_BIT 5
`define UHIASR_UE_BIT 4
`define UHIASR_RD_BIT 3
`define UHIASR_SF_BIT 2
`define UHIASR_WDH_BIT 1
`define UHIASR_SO_BIT 0
`define UHIASR_FS_LSB 6
`define UHIASR_ROUTE_BIT 8
`define UHIASR_SRST_BIT 0
`define UHIASR_ENABLE_RESET 32'h0000_0000
`define UHIASR_STATUS_RESET 32'h0000_0000
`define UHIASR_SRST_MAX_US 10
`define UHIASR_CLK_MHZ 100
`define UHIASR_SRST_MAX_CYC (`UHIASR_SRST_MAX_US * `UHIASR_CLK_MHZ)
`define UHIASR_SRST_CYC 8
`endif

// *** rtl/uhiasr_pkg.sv ***
// Types and address decode shared by the block's modules.
`include "uhiasr_map.svh"
package uhiasr_pkg;
   typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_BUSY = 2'b10} uhiasr_seq_e;
   typedef enum logic [1:0] {
      FS_RESET = 2'b00, FS_RESUME = 2'b01, FS_OPER = 2'b10, FS_SUSPEND = 2'b11
   } uhiasr_fs_e;
   typedef logic [`UHIASR_ADDR_W-1:0] uhiasr_addr_t;
   function automatic logic reg_hit(input uhiasr_addr_t a);
      return (a == `UHIASR_OFS_CTRL) || (a == `UHIASR_OFS_CMD) ||
             (a == `UHIASR_OFS_STATUS) || (a == `UHIASR_OFS_EN_SET) ||
             (a == `UHIASR_OFS_EN_CLR);
   endfunction
endpackage

// *** rtl/uhiasr_reg_if.sv ***
// Register access strobes between the bus slave and the register file.
`timescale 1ns/1ps
interface uhiasr_reg_if;
   logic wr;
   logic rd;
   uhiasr_pkg::uhiasr_addr_t addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport bus (output wr, output rd, output addr, output wdata, input rdata);
   modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// *** rtl/uhiasr_apb_slave.sv ***
// Zero-wait APB slave that turns access phases into register strobes.
`timescale 1ns/1ps
module uhiasr_apb_slave (
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire uhiasr_pkg::uhiasr_addr_t paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   uhiasr_reg_if.bus rif
);
   logic access;
   logic hit;
   // =====================================================
   // Decode
   // =====================================================
   assign access = psel_in && penable_in;
   assign hit = uhiasr_pkg::reg_hit(paddr_in);
   assign rif.wr = access && pwrite_in && hit;
   assign rif.rd = access && !pwrite_in && hit;
   assign rif.addr = paddr_in;
   assign rif.wdata = pwdata_in;
   assign pready_out = 1'b1;
   assign pslverr_out = access && !hit;
   assign prdata_out = hit ? rif.rdata : 32'h0000_0000;
endmodule // uhiasr_apb_slave

// *** rtl/uhiasr_srst_seq.sv ***
// Software reset sequencer that holds busy for a fixed number of cycles.
`timescale 1ns/1ps
`include "uhiasr_map.svh"
module uhiasr_srst_seq #(
   parameter int SRST_CYCLES = `UHIASR_SRST_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   output logic busy_out,
   output logic done_out
);
   typedef struct packed {
      uhiasr_pkg::uhiasr_seq_e state;
      logic [15:0] cnt;
   } uhiasr_seq_s;
   uhiasr_seq_s q;
   uhiasr_seq_s next_q;
   if (SRST_CYCLES < 1 || SRST_CYCLES > `UHIASR_SRST_MAX_CYC) begin : g_bad_len
      $error("Software reset length out of range.");
   end
   // =====================================================
   // Sequencer
   // =====================================================
   always_comb begin
      next_q = q;
      done_out = 1'b0;
      unique case (q.state)
         uhiasr_pkg::SEQ_IDLE: begin
            if (start_in) begin
               next_q.state = uhiasr_pkg::SEQ_BUSY;
               next_q.cnt = 16'(SRST_CYCLES - 1);
            end
         end
         uhiasr_pkg::SEQ_BUSY: begin
            if (q.cnt == 16'h0000) begin
               next_q.state = uhiasr_pkg::SEQ_IDLE;
               done_out = 1'b1;
            end else begin
               next_q.cnt = q.cnt - 16'h0001;
            end
         end
         default: next_q.state = uhiasr_pkg::SEQ_IDLE;
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '{state: uhiasr_pkg::SEQ_IDLE, cnt: 16'h0000};
      end else begin
         q <= next_q;
      end
   end
   assign busy_out = (q.state == uhiasr_pkg::SEQ_BUSY);
endmodule // uhiasr_srst_seq

// *** verif/uhiasr_evt_src.sv ***
// Event source model that turns one-cycle requests into event pulses.
`timescale 1ns/1ps
// ==========================================================
// Event pulse source
module uhiasr_evt_src (
   input wire logic clk_in,
   input wire logic [31:0] fire_in,
   output logic [31:0] evt_out
);
   initial evt_out = 32'h0000_0000;
   // Each request bit becomes one event pulse one cycle later.
   always @(posedge clk_in) begin
      evt_out <= fire_in;
   end
endmodule // uhiasr_evt_src

// *** verif/testbench.sv ***
// Self-checking testbench for the event status, enables, interrupts and soft reset.
`timescale 1ns/1ps
module testbench;
   localparam int SRST = 4;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, smi, bus_en, port_rst, busy;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, evt, fire, rd, acc;
   logic err, done;
   int fails, compares, n;
   int bits[8] = '{30, 6, 5, 4, 3, 2, 1, 0};

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   uhiasr_evt_src i_src (.clk_in(clk), .fire_in(fire), .evt_out(evt));
   uhiasr_top #(.SRST_CYCLES(SRST)) i_dut (
      .core_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .evt_in(evt), .irq_out(irq),
      .smi_out(smi), .bus_access_en_out(bus_en), .port_reset_out(port_rst),
      .soft_reset_busy_out(busy));

   // ==========================================================
   // Checking and closing
   task automatic end_of_test;
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // ==========================================================
   // Bus access, event pulse and interrupt check tasks
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      logic rdy;
      k = 0;
      rdy = 1'b0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      while (!rdy) begin
         @(posedge clk);
         rdy = (pready === 1'b1);
         rd = prdata;
         err = pslverr;
         k++;
         if (!rdy && k > 50) begin
            fails++;
            $display("[ERR] pready expected 1 seen 0");
            end_of_test;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask
   task automatic pulse(input logic [31:0] v);
      @(posedge clk);
      fire <= v;
      @(posedge clk);
      fire <= 32'h0000_0000;
   endtask
   task automatic chk_int(input logic ei, input logic es);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk1("irq_out", ei, irq);
      chk1("smi_out", es, smi);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      fire = 32'h0000_0000;
      fails = 0;
      compares = 0;
      acc = 32'h0000_0000;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk1("port_reset", 1'b1, port_rst);
      rdc("enable", 16'hd010, 32'h0000_0000);
      rdc("disable", 16'hd014, 32'h0000_0000);
      rdc("status", 16'hd00c, 32'h0000_0000);
      apb(1'b0, 16'hd020, 32'h0000_0000);
      chk1("unmapped_err", 1'b1, err);
      chk("unmapped_rd", 32'h0000_0000, rd);
      wr(16'hd010, 32'h0000_0005);
      wr(16'hd010, 32'h0000_0002);
      rdc("enable", 16'hd010, 32'h0000_0007);
      wr(16'hd014, 32'h0000_0001);
      rdc("disable", 16'hd014, 32'h0000_0006);
      wr(16'hd014, 32'hffff_ffff);
      rdc("enable", 16'hd010, 32'h0000_0000);
      foreach (bits[i]) begin
         pulse(32'h0000_0001 << bits[i]);
         acc = acc | (32'h0000_0001 << bits[i]);
         rdc("status", 16'hd00c, acc);
      end
      pulse(32'hbfff_ff80);
      rdc("status", 16'hd00c, acc);
      wr(16'hd00c, 32'h0000_0000);
      rdc("status", 16'hd00c, acc);
      repeat (20) @(posedge clk);
      rdc("status", 16'hd00c, acc);
      wr(16'hd00c, 32'h0000_0001);
      acc = acc & 32'hffff_fffe;
      rdc("status", 16'hd00c, acc);
      wr(16'hd010, 32'h0000_0004);
      chk_int(1'b0, 1'b0);
      wr(16'hd010, 32'h8000_0000);
      chk_int(1'b1, 1'b0);
      wr(16'hd004, 32'h0000_0100);
      chk_int(1'b0, 1'b1);
      wr(16'hd004, 32'h0000_0000);
      chk_int(1'b1, 1'b0);
      wr(16'hd010, 32'h0000_0000);
      chk_int(1'b1, 1'b0);
      wr(16'hd00c, 32'h0000_0004);
      chk_int(1'b0, 1'b0);
      wr(16'hd010, 32'h0000_0002);
      chk_int(1'b1, 1'b0);
      wr(16'hd014, 32'h0000_0002);
      chk_int(1'b0, 1'b0);
      wr(16'hd004, 32'h0000_0180);
      @(negedge clk);
      chk1("bus_access_en", 1'b1, bus_en);
      wr(16'hd008, 32'h0000_0001);
      n = 0;
      done = 1'b0;
      for (int i = 0; i < 1100 && !done; i++) begin
         @(negedge clk);
         if (busy === 1'b1) begin
            n++;
            chk1("bus_access_en", 1'b0, bus_en);
            chk1("port_reset", 1'b0, port_rst);
         end else begin
            done = 1'b1;
         end
      end
      if (!done) begin
         fails++;
         $display("[ERR] soft_reset_busy expected 0 seen 1");
         end_of_test;
      end
      chk("busy_cycles", SRST, n);
      rdc("command", 16'hd008, 32'h0000_0000);
      rdc("control", 16'hd004, 32'h0000_01c0);
      rdc("enable", 16'hd010, 32'h0000_0000);
      rdc("status", 16'hd00c, 32'h0000_0000);
      end_of_test;
   end
endmodule // testbench
